// File: ccs_pkg.sv
package ccs_pkg;
	// supervision inputs, one bit per monitored condition
	typedef struct packed {
		logic vcc_over;
		logic vcc_under;
		logic bat_over;
		logic bat_under;
	} ccs_flt_t;

	// card supply control states, gray coded along off-on-down and off-min; down-off changes both bits
	typedef enum logic [1:0] {
		CCS_OFF  = 2'b00,
		CCS_ON   = 2'b01,
		CCS_DOWN = 2'b11,
		CCS_MIN  = 2'b10
	} ccs_pwr_t;

	localparam int CLK_PERIOD_NS = 50;
	// length of the card power-down sequence
	localparam int PDN_TIME_NS   = 200;
	localparam int PDN_CYC       =
		(PDN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] PDN_CNT_LAST = 4'(PDN_CYC - 1);
	localparam logic [3:0] PDN_CNT_RST  = 4'h0;
	localparam int SYNC_W = 11;
endpackage

// File: ccs_coupler.sv
`timescale 1ns/10ps

// two-stage synchroniser for pin inputs
module ccs_sync #(
	parameter int W = 1
) (
	input  wire logic         i_mclk, // system clock
	input  wire logic         i_nrst, // async reset, low
	input  wire logic [W-1:0] i_d,    // asynchronous input
	output logic      [W-1:0] o_q     // synchronised output
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
		begin
			meta <= '0;
			o_q  <= '0;
		end
		else
		begin
			meta <= i_d;
			o_q  <= meta;
		end
endmodule

module ccs_coupler
	import ccs_pkg::*;
(
	input  wire logic     i_mclk,               // 20 MHz clock
	input  wire logic     i_nrst,               // async reset, low
	input  wire logic     i_sel_n,              // coupler select, low
	input  wire logic     i_card_power_request, // supply request
	input  wire logic     i_prog_n,             // programming, low
	input  wire logic     i_host_data,          // host data level
	input  wire logic     i_host_reset,         // host reset level
	input  wire logic     i_clock_run,          // clock run program
	input  wire logic     i_card_presence_sense,// card present, high
	input  wire ccs_flt_t i_flt,                // analog monitors
	output logic          o_host_in_en,         // host inputs live
	output logic          o_status,             // status, high ok
	output logic          o_status_oe_n,        // status enable, low
	output logic          o_attn_n,             // attention, low
	output logic          o_card_data_line,     // card data level
	output logic          o_card_reset_line,    // card reset level
	output logic          o_card_clock_en,      // card clock running
	output logic          o_card_supply,        // supply converter on
	output logic          o_sub_en              // non-minimum parts on
);
	logic [SYNC_W-1:0] sync_q;
	logic              s_sel_n;
	logic              s_pwr;
	logic              s_prog_n;
	logic              s_hdata;
	logic              s_hrst;
	logic              s_clk_run;
	logic              s_present;
	ccs_flt_t          s_flt;
	logic              sel_q;
	logic              pwr_q;
	logic              present_q;
	logic              selected;
	logic              sel_rise;
	logic              pwr_rise;
	logic              pwr_fall;
	logic              bat_fault;
	logic              vcc_fault;
	logic              attn_set;
	logic              attn_clr;
	logic              attn;
	logic              fault_hold;
	logic              clk_run;
	logic [3:0]        pdn_cnt;
	ccs_pwr_t          state;
	ccs_pwr_t          next_state;

	// every pin passes two flip-flops
	ccs_sync #(.W(SYNC_W)) u_sync (
		.i_mclk (i_mclk),
		.i_nrst (i_nrst),
		.i_d    ({i_sel_n, i_card_power_request, i_prog_n, i_host_data,
			i_host_reset, i_clock_run, i_card_presence_sense, i_flt}),
		.o_q    (sync_q)
	);
	assign {s_sel_n, s_pwr, s_prog_n, s_hdata, s_hrst, s_clk_run,
		s_present, s_flt} = sync_q;

	// edge history of select, power request and presence
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
		begin
			sel_q     <= 1'b1;
			pwr_q     <= 1'b0;
			present_q <= 1'b0;
		end
		else
		begin
			sel_q     <= s_sel_n;
			pwr_q     <= s_pwr;
			present_q <= s_present;
		end

	// decoded events
	assign selected  = ~s_sel_n;
	assign sel_rise  = s_sel_n & ~sel_q;
	assign pwr_rise  = s_pwr & ~pwr_q;
	assign pwr_fall  = ~s_pwr & pwr_q;
	assign bat_fault = s_flt.bat_over | s_flt.bat_under;
	assign vcc_fault = s_flt.vcc_over | s_flt.vcc_under;

	// host-side pins live only while selected
	assign o_host_in_en  = selected;
	assign o_status_oe_n = s_sel_n;

	// card data (not while programming) and reset follow host only when on and selected; low when not on, data high in reset; else hold
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
		begin
			o_card_data_line  <= 1'b1;
			o_card_reset_line <= 1'b0;
		end
		else if (state != CCS_ON)
		begin
			o_card_data_line  <= 1'b0; // line grounded when unpowered
			o_card_reset_line <= 1'b0;
		end
		else if (selected)
		begin
			if (s_prog_n)
				o_card_data_line <= s_hdata;
			o_card_reset_line <= s_hrst;
		end

	// clock run state programmed only while selected and programming
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
			clk_run <= 1'b0;
		else if (selected && !s_prog_n)
			clk_run <= s_clk_run;

	// clock and supply independent of select
	assign o_card_clock_en = clk_run & (state == CCS_ON);
	assign o_card_supply   = (state == CCS_ON);
	assign o_sub_en        = (state != CCS_MIN);

	// supply control
	always_comb
	begin
		next_state = state;
		case (state)
			CCS_OFF:
				if (selected && pwr_rise && !bat_fault)
					next_state = CCS_ON;
				else if (s_sel_n && s_hdata && !attn && !s_present)
					next_state = CCS_MIN;
			CCS_ON:
				if (bat_fault)
					next_state = CCS_DOWN;
				else if (selected && pwr_fall)
					next_state = CCS_DOWN;
			CCS_DOWN:
				if (pdn_cnt == PDN_CNT_LAST)
					next_state = CCS_OFF;
			CCS_MIN:
				if (s_present || selected)
					next_state = CCS_OFF;
			default:
				next_state = CCS_OFF;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
			state <= CCS_OFF;
		else
			state <= next_state;

	// power-down sequence length
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
			pdn_cnt <= PDN_CNT_RST;
		else if (state == CCS_DOWN)
			pdn_cnt <= pdn_cnt + 4'h1;
		else
			pdn_cnt <= PDN_CNT_RST;

	// status follows faults; reading never clears it
	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
			fault_hold <= 1'b0;
		else
			fault_hold <= vcc_fault | bat_fault;

	assign o_status = ~fault_hold;

	// attention on card change or supply overload, set wins
	assign attn_set = (s_present ^ present_q) |
		(s_flt.vcc_under & (state == CCS_ON));
	assign attn_clr = sel_rise | (selected & pwr_rise);

	always_ff @(posedge i_mclk or negedge i_nrst)
		if (!i_nrst)
			attn <= 1'b0;
		else if (attn_set)
			attn <= 1'b1;
		else if (attn_clr)
			attn <= 1'b0;

	assign o_attn_n = ~attn;

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	sequence seq_sel_pwr_rise;
		selected && pwr_rise && !bat_fault && state == CCS_OFF;
	endsequence
	sequence seq_on;
		state == CCS_ON;
	endsequence

	chk_fault_status: assert property (
		(vcc_fault | bat_fault) |=> !o_status)
		else $error("status not showing fault");
	chk_bat_powerdown: assert property (
		(state == CCS_ON && bat_fault) |=> state == CCS_DOWN ##4
		state == CCS_OFF)
		else $error("battery fault did not power down");
	chk_host_enable: assert property (
		o_host_in_en == !s_sel_n)
		else $error("host input enable wrong");
	chk_status_float: assert property (
		s_sel_n |-> o_status_oe_n)
		else $error("status driven while deselected");
	chk_hold_lines: assert property (
		(s_sel_n && state == CCS_ON && $past(state) == CCS_ON) |=>
		$stable(o_card_data_line) && $stable(o_card_reset_line))
		else $error("card lines moved while deselected");
	chk_power_up: assert property (
		seq_sel_pwr_rise |=> seq_on ##0 o_card_supply)
		else $error("supply not started");
	chk_desel_fall: assert property (
		(state == CCS_ON && s_sel_n && !bat_fault) |=> seq_on)
		else $error("supply dropped while deselected");
	chk_min_sub: assert property (
		(state == CCS_MIN) |-> !o_sub_en && !o_card_supply)
		else $error("sub functions active in minimum power");
	chk_wake: assert property (
		(state == CCS_MIN && (s_present || selected)) |=> o_sub_en)
		else $error("no wake from minimum power");
	chk_attn_clear: assert property (
		(attn && attn_clr && !attn_set) |=> o_attn_n)
		else $error("attention not cleared");
	chk_fault_hold: assert property (
		(!o_status && (vcc_fault | bat_fault)) |=> !o_status)
		else $error("status cleared while fault present");
endmodule

// File: ccs_host.sv
`timescale 1ns/10ps

// host side model owning this coupler's own select line
module ccs_host (
	input  wire logic i_mclk,  // system clock
	output logic      o_sel_n, // select, low
	output logic      o_req,   // card power request
	output logic      o_prog_n,// programming, low
	output logic      o_data,  // host data level
	output logic      o_rst,   // host reset level
	output logic      o_run    // clock run value
);
	// idle: deselected, request off, data line high
	initial
	begin
		{o_sel_n, o_req, o_prog_n, o_data, o_rst, o_run} = 6'h2C;
	end

	// new pin set just after an edge, then held for n cycles
	task put(input logic [5:0] v, input int n);
		@(posedge i_mclk);
		{o_sel_n, o_req, o_prog_n, o_data, o_rst, o_run} <= v;
		repeat (n) @(posedge i_mclk);
	endtask
endmodule

// File: tb_card_coupler_select_and_supervision.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((e) !== (a)) begin \
bad_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end

module tb_card_coupler_select_and_supervision;
	import ccs_pkg::*;
	logic        i_mclk, i_nrst, i_sel_n, i_card_power_request, i_prog_n;
	logic        i_host_data, i_host_reset, i_clock_run;
	logic        i_card_presence_sense;
	ccs_flt_t    i_flt;
	logic        o_host_in_en, o_status, o_status_oe_n, o_attn_n, o_sub_en;
	logic        o_card_data_line, o_card_reset_line, o_card_clock_en;
	logic        o_card_supply;
	logic [8:0]  obs;
	logic [17:0] nt;
	logic [17:0] notes[$];
	logic [31:0] d;
	int          bad_count, check_count;

	ccs_coupler ccs_coupler_inst (.i_mclk, .i_nrst, .i_sel_n,
		.i_card_power_request, .i_prog_n, .i_host_data, .i_host_reset,
		.i_clock_run, .i_card_presence_sense, .i_flt, .o_host_in_en,
		.o_status, .o_status_oe_n, .o_attn_n, .o_card_data_line,
		.o_card_reset_line, .o_card_clock_en, .o_card_supply, .o_sub_en);
	ccs_host ccs_host_inst (.i_mclk, .o_sel_n(i_sel_n),
		.o_req(i_card_power_request), .o_prog_n(i_prog_n),
		.o_data(i_host_data), .o_rst(i_host_reset), .o_run(i_clock_run));

	// output vector in a fixed bit order for masked compares
	assign obs = {o_card_supply, o_card_data_line, o_card_reset_line,
		o_card_clock_en, o_attn_n, o_status, o_status_oe_n, o_host_in_en,
		o_sub_en};

	// clock generator
	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// compare each pending note against the settled outputs
	always @(negedge i_mclk)
	begin
		while (notes.size() > 0)
		begin
			nt = notes.pop_front();
			`CHK("outputs", nt[8:0] & nt[17:9], obs & nt[17:9])
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	task note(input logic [8:0] m, input logic [8:0] v);
		notes.push_back({m, v});
	endtask

	task cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard
	initial
	begin
		cyc(4000);
		bad_count++;
		stop_test();
	end

	// main sequence
	initial
	begin
		i_nrst = 1'b0;
		i_card_presence_sense = 1'b0;
		i_flt = 4'h0;
		d = 32'h0001_0BD7;
		cyc(2);
		i_nrst <= 1'b1;
		note(9'h119, 9'h019);
		cyc(6);
		i_card_presence_sense <= 1'b1;
		cyc(6);
		note(9'h010, 9'h000);
		ccs_host_inst.put(6'b000101, 4);
		ccs_host_inst.put(6'b011101, 6);
		note(9'h136, 9'h132);
		repeat (4)
		begin
			d = xs(d);
			ccs_host_inst.put({3'b011, d[0], d[1], 1'b1}, 5);
			note(9'h0C0, {1'b0, d[0], d[1], 6'h00});
		end
		ccs_host_inst.put({3'b111, d[0], d[1], 1'b1}, 5);
		ccs_host_inst.put({3'b100, ~d[0], ~d[1], 1'b1}, 6);
		note(9'h1E6, {1'b1, d[0], d[1], 1'b1, 2'b00, 1'b1, 2'b00});
		ccs_host_inst.put({3'b010, ~d[0], d[1], 1'b1}, 6);
		note(9'h180, {1'b1, d[0], 7'h00});
		ccs_host_inst.put(6'b011101, 4);
		for (int i = 3; i >= 0; i--)
		begin
			@(posedge i_mclk);
			i_flt <= ccs_flt_t'(4'h1 << i);
			cyc(12);
			note(9'h108, {(i >= 2), 8'h00});
			@(posedge i_mclk);
			i_flt <= 4'h0;
			cyc(6);
			ccs_host_inst.put(6'b001101, 10);
			ccs_host_inst.put(6'b011101, 6);
			note(9'h108, 9'h108);
		end
		ccs_host_inst.put(6'b001101, 10);
		i_card_presence_sense <= 1'b0;
		cyc(6);
		ccs_host_inst.put(6'b101100, 10);
		note(9'h101, 9'h000);
		ccs_host_inst.put(6'b001100, 6);
		note(9'h001, 9'h001);
		ccs_host_inst.put(6'b101100, 10);
		note(9'h001, 9'h000);
		i_card_presence_sense <= 1'b1;
		cyc(6);
		note(9'h001, 9'h001);
		cyc(2);
		stop_test();
	end
endmodule
